// file: design/nvpc_device.sv
// Purpose: local device end of the presentation codec
// Assumes: variable table of NVPC_VAR_N entries held in flip-flops
// Notes: encodes sends, decodes receives, tracks poll completion
// Summary of operation
// - nv code: top bit one, six high selector
// - second byte holds eight low selector bits
// - direction bit zero input, one output
// - update carries one to thirty-one value bytes
// - values sent most significant byte first
// - app code: top bits zero, 0-249 data
// - foreign code: upper nibble 0100, 0-249 data
// - updates only into inputs; polls read both
// - poll request: top bits set, selector only
// - response clears bit six, selector, value
// - no match or offline: no value bytes
// - response updates input of equal selector, size
// - group members ack; only matching outputs return data (this device end also returns data for matching inputs)
// - every response to an outstanding poll raises an update event
// - success when all answer, failure after retries
// - scaled equals a times ten^b times (raw plus c); negative b divides by ten once
// - clamp to min/max; invalid means unknown
// - unsigned quad 32 bits, short 8 bits
// - fetch by table index, poll by selector
`timescale 1ns/100ps
`default_nettype none
module nvpc_device
  import nvpc_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // send request
  input wire logic i_send,
  input wire nvpc_kind_t i_kind,
  input wire logic [NVPC_SEL_W-1:0] i_sel,
  input wire logic [5:0] i_code,
  input wire logic [7:0] i_len,
  input wire logic [NVPC_VAL_W-1:0] i_val,
  input wire logic [3:0] i_expect,
  output logic o_busy,
  // table set-up and fetch by index
  input wire logic i_tab_we,
  input wire logic [1:0] i_tab_idx,
  input wire logic [NVPC_SEL_W-1:0] i_tab_sel,
  input wire logic [5:0] i_tab_len,
  input wire logic i_tab_out,
  input wire logic [NVPC_VAL_W-1:0] i_tab_val,
  output logic [NVPC_VAL_W-1:0] o_fetch_val,
  // scaling of fetched value
  input wire logic signed [15:0] i_scale_a,
  input wire logic signed [3:0] i_scale_b,
  input wire logic signed [31:0] i_scale_c,
  input wire logic signed [31:0] i_min,
  input wire logic signed [31:0] i_max,
  input wire logic signed [31:0] i_invalid,
  output logic signed [63:0] o_scaled,
  output logic o_unknown,
  // events
  input wire logic i_timeout,
  output logic o_upd_evt,
  output logic o_upd_ok,
  output logic o_upd_fail,
  output logic [NVPC_SEL_W-1:0] o_rx_sel,
  // link
  nvpc_link_if.device lk
);
  typedef enum {NVPC_D_IDLE, NVPC_D_LO, NVPC_D_DAT} nvpc_dst_t;
  nvpc_dst_t st_r, st_nxt;
  logic [7:0] txd_r, txd_nxt;
  logic txv_r, txv_nxt;
  logic txl_r, txl_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [7:0] len_r, len_nxt;
  logic [NVPC_VAL_W-1:0] val_r, val_nxt;
  logic [7:0] lo_r, lo_nxt;
  logic [7:0] tlo_r, tlo_nxt;
  logic [3:0] pend_r, pend_nxt;
  logic [3:0] retry_r, retry_nxt;
  logic ok_r, ok_nxt;
  logic fail_r, fail_nxt;
  logic evt_r, evt_nxt;
  logic [NVPC_SEL_W-1:0] rsel_r, rsel_nxt;
  // receive side
  logic [1:0] rpos_r, rpos_nxt;
  logic [7:0] rcode_r, rcode_nxt;
  logic [5:0] rcnt_r, rcnt_nxt;
  logic [NVPC_VAL_W-1:0] racc_r, racc_nxt;
  // table
  logic [NVPC_SEL_W-1:0] t_sel_r [NVPC_VAR_N];
  logic [5:0] t_len_r [NVPC_VAR_N];
  logic t_out_r [NVPC_VAR_N];
  logic [NVPC_VAL_W-1:0] t_val_r [NVPC_VAR_N];
  logic [NVPC_VAR_N-1:0] wr_hit;
  logic [NVPC_VAR_N-1:0] a_hit;
  logic [NVPC_SEL_W-1:0] cur_sel;
  logic rx_fire, rx_end;
  logic signed [63:0] scl_r, scl_nxt;
  logic unk_r, unk_nxt;
  logic signed [31:0] clamp;
  logic signed [63:0] pw;

  assign lk.tx_data = txd_r;
  assign lk.tx_valid = txv_r;
  assign lk.tx_last = txl_r;
  assign lk.rx_ready = 1'b1;
  assign o_busy = txv_r;
  assign o_upd_evt = evt_r;
  assign o_upd_ok = ok_r;
  assign o_upd_fail = fail_r;
  assign o_rx_sel = rsel_r;
  assign o_scaled = scl_r;
  assign o_unknown = unk_r;
  assign o_fetch_val = t_val_r[i_tab_idx]; // fetch by index
  assign rx_fire = lk.rx_valid;
  assign rx_end = rx_fire && lk.rx_last;
  // join the two selector halves
  assign cur_sel = {rcode_r[NVPC_HI_W-1:0],
                    rpos_r == 2'd1 ? lk.rx_data : lo_r};

  // transmit encoder
  always_comb begin
    st_nxt = st_r;
    txd_nxt = txd_r;
    txv_nxt = txv_r;
    txl_nxt = txl_r;
    cnt_nxt = cnt_r;
    len_nxt = len_r;
    val_nxt = val_r;
    tlo_nxt = tlo_r;
    case (st_r)
      NVPC_D_IDLE: begin
        if (i_send) begin
          txv_nxt = 1'b1;
          val_nxt = i_val;
          cnt_nxt = 8'h00;
          len_nxt = i_len;
          tlo_nxt = i_sel[7:0];
          st_nxt = NVPC_D_DAT;
          case (i_kind)
            NVPC_K_APP: txd_nxt = {NVPC_APP_TOP, i_code};
            NVPC_K_FRN: txd_nxt = {NVPC_FRN_TOP, i_code[3:0]};
            NVPC_K_POLL: begin
              txd_nxt = {NVPC_POLL_TOP, i_sel[13:8]};
              len_nxt = 8'h00;
              st_nxt = NVPC_D_LO;
            end
            default: begin
              // nv update to an input: bit7 one, dir zero
              txd_nxt = {1'b1, 1'b0, i_sel[13:8]};
              // clip length to 1..31 bytes
              len_nxt = (i_len == 8'h00) ? 8'h01 :
                        (i_len > 8'(NVPC_NV_MAX)) ? 8'(NVPC_NV_MAX) : i_len;
              st_nxt = NVPC_D_LO;
            end
          endcase
          if (i_kind == NVPC_K_APP || i_kind == NVPC_K_FRN) begin
            if (i_len > 8'(NVPC_MSG_MAX)) len_nxt = 8'(NVPC_MSG_MAX);
            txl_nxt = i_len == 8'h00;
          end else begin
            txl_nxt = 1'b0;
          end
        end else if (rx_end && rpos_r == 2'd1 && &rcode_r[7:6]) begin
          // answer a poll; one arriving while busy is lost
          txd_nxt = rcode_r & 8'hBF;
          txv_nxt = 1'b1;
          tlo_nxt = lk.rx_data;
          cnt_nxt = 8'h00;
          len_nxt = 8'h00; // no match: no value bytes
          st_nxt = NVPC_D_LO;
          for (int k = 0; k < NVPC_VAR_N; k++)
            if (a_hit[k]) {len_nxt, val_nxt} = {8'(t_len_r[k]), t_val_r[k]};
        end
      end
      NVPC_D_LO: begin
        if (lk.tx_ready) begin
          txd_nxt = tlo_r; // selector low byte
          txl_nxt = len_r == 8'h00;
          st_nxt = NVPC_D_DAT;
        end
      end
      NVPC_D_DAT: begin
        if (lk.tx_ready) begin
          if (txl_r) begin
            txv_nxt = 1'b0;
            txl_nxt = 1'b0;
            st_nxt = NVPC_D_IDLE;
          end else begin
            // msb first out of a 32-bit quad, zero beyond
            txd_nxt = (len_r - cnt_r > 8'h04) ? NVPC_ZERO_B :
                      val_r[8*(len_r-cnt_r-8'h01) +: 8];
            cnt_nxt = cnt_r + 8'h01;
            txl_nxt = cnt_r + 8'h01 == len_r;
          end
        end
      end
      default: st_nxt = NVPC_D_IDLE;
    endcase
  end

  // receive decoder and poll tracking
  always_comb begin
    rpos_nxt = rpos_r;
    rcode_nxt = rcode_r;
    rcnt_nxt = rcnt_r;
    racc_nxt = racc_r;
    lo_nxt = lo_r;
    pend_nxt = pend_r;
    retry_nxt = retry_r;
    ok_nxt = 1'b0;
    fail_nxt = 1'b0;
    evt_nxt = 1'b0;
    rsel_nxt = rsel_r;
    if (st_r == NVPC_D_IDLE && i_send && i_kind == NVPC_K_POLL) begin
      pend_nxt = i_expect;
      retry_nxt = NVPC_RETRY_RST;
    end
    if (rx_fire) begin
      case (rpos_r)
        2'd0: rcode_nxt = lk.rx_data;
        2'd1: lo_nxt = lk.rx_data;
        default: begin
          racc_nxt = {racc_r[23:0], lk.rx_data}; // msb first
          rcnt_nxt = rcnt_r + 6'h01;
        end
      endcase
      rpos_nxt = rx_end ? 2'd0 : (rpos_r == 2'd0 ? 2'd1 : 2'd2);
      if (rpos_r == 2'd0) rcnt_nxt = 6'h00;
    end
    if (rx_end && rpos_r != 2'd0 && rcode_r[NVPC_NV_BIT] &&
        !rcode_r[NVPC_DIR_BIT]) begin
      rsel_nxt = cur_sel;
      // every answer to an outstanding poll is an event
      if (pend_r != 4'h0) begin
        evt_nxt = 1'b1;
        pend_nxt = pend_r - 4'h1;
        ok_nxt = pend_r == 4'h1; // all answered
      end
    end
    if (i_timeout && pend_r != 4'h0) begin
      if (retry_r == 4'h0) begin
        fail_nxt = 1'b1; // still missing after retries
        pend_nxt = 4'h0;
      end else begin
        retry_nxt = retry_r - 4'h1;
      end
    end
  end

  // table write: inputs only, matching selector and size
  for (genvar g = 0; g < NVPC_VAR_N; g++) begin : g_tab
    always_comb begin
      a_hit[g] = t_sel_r[g] == cur_sel; // poll match per entry
      wr_hit[g] = rx_end && rpos_r == 2'd2 && rcode_r[NVPC_NV_BIT] &&
                  !rcode_r[NVPC_DIR_BIT] && !t_out_r[g] &&
                  t_sel_r[g] == cur_sel &&
                  t_len_r[g] == rcnt_r + 6'h01;
    end
    always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
        t_sel_r[g] <= '0;
        t_len_r[g] <= 6'h00;
        t_out_r[g] <= 1'b0;
        t_val_r[g] <= NVPC_VAL_RST;
      end else if (i_tab_we && i_tab_idx == 2'(g)) begin
        t_sel_r[g] <= i_tab_sel;
        t_len_r[g] <= i_tab_len;
        t_out_r[g] <= i_tab_out;
        t_val_r[g] <= i_tab_val;
      end else if (wr_hit[g]) begin
        t_val_r[g] <= {racc_r[23:0], lk.rx_data};
      end
    end
  end

  // scaling with clamp and invalid detection
  always_comb begin
    clamp = $signed(o_fetch_val);
    if (clamp < i_min) clamp = i_min;
    if (clamp > i_max) clamp = i_max;
    pw = 64'sd1;
    for (int k = 0; k < 7; k++) begin
      if (k < i_scale_b) pw = pw * 64'sd10;
    end
    scl_nxt = 64'(i_scale_a * pw * (64'(clamp) + 64'(i_scale_c)));
    if (i_scale_b < 0) scl_nxt = scl_nxt / 64'sd10;
    unk_nxt = $signed(o_fetch_val) == i_invalid;
  end

  // state registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      st_r <= NVPC_D_IDLE;
      txd_r <= NVPC_ZERO_B;
      txv_r <= 1'b0;
      txl_r <= 1'b0;
      cnt_r <= 8'h00;
      len_r <= 8'h00;
      val_r <= NVPC_VAL_RST;
      lo_r <= NVPC_ZERO_B;
      tlo_r <= NVPC_ZERO_B;
      pend_r <= 4'h0;
      retry_r <= NVPC_RETRY_RST;
      ok_r <= 1'b0;
      fail_r <= 1'b0;
      evt_r <= 1'b0;
      rsel_r <= '0;
      rpos_r <= 2'd0;
      rcode_r <= NVPC_ZERO_B;
      rcnt_r <= 6'h00;
      racc_r <= NVPC_VAL_RST;
      scl_r <= 64'sd0;
      unk_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      txd_r <= txd_nxt;
      txv_r <= txv_nxt;
      txl_r <= txl_nxt;
      cnt_r <= cnt_nxt;
      len_r <= len_nxt;
      val_r <= val_nxt;
      lo_r <= lo_nxt;
      tlo_r <= tlo_nxt;
      pend_r <= pend_nxt;
      retry_r <= retry_nxt;
      ok_r <= ok_nxt;
      fail_r <= fail_nxt;
      evt_r <= evt_nxt;
      rsel_r <= rsel_nxt;
      rpos_r <= rpos_nxt;
      rcode_r <= rcode_nxt;
      rcnt_r <= rcnt_nxt;
      racc_r <= racc_nxt;
      scl_r <= scl_nxt;
      unk_r <= unk_nxt;
    end
  end
endmodule
`default_nettype wire

// file: design/nvpc_pkg.sv
// Purpose: shared constants and types for the presentation codec ends
// Assumes: byte-wide message stream with valid/ready and last marker
// Notes: selector is 14 bits, split 6 high / 8 low
package nvpc_pkg;
  localparam int NVPC_SEL_W = 14;
  localparam int NVPC_HI_W = 6;
  localparam int NVPC_LO_W = 8;
  localparam int NVPC_NV_MAX = 31;
  localparam int NVPC_MSG_MAX = 249;
  localparam int NVPC_VAR_N = 4;
  localparam int NVPC_VAL_W = 32;
  localparam int NVPC_NV_BIT = 7;
  localparam int NVPC_DIR_BIT = 6;
  localparam logic [1:0] NVPC_APP_TOP = 2'h0;
  localparam logic [3:0] NVPC_FRN_TOP = 4'h4;
  localparam logic [1:0] NVPC_POLL_TOP = 2'h3;
  localparam logic [3:0] NVPC_RETRY_RST = 4'h3;
  localparam logic [7:0] NVPC_ZERO_B = 8'h00;
  localparam logic [NVPC_VAL_W-1:0] NVPC_VAL_RST = 32'h0000_0000;
  // message kinds the user side can request or see
  typedef enum logic [2:0] {
    NVPC_K_UPD, NVPC_K_POLL, NVPC_K_RESP, NVPC_K_APP, NVPC_K_FRN
  } nvpc_kind_t;
endpackage

// file: design/nvpc_link_if.sv
// Purpose: byte stream link between local device end and remote node end
// Assumes: one clock, byte accepted when valid and ready are both high
// Notes: each direction carries one message, last marks its final byte
`timescale 1ns/100ps
`default_nettype none
interface nvpc_link_if (input wire logic i_ref_clk);
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_last;
  logic tx_ready;
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_last;
  logic rx_ready;
  modport device (output tx_data, tx_valid, tx_last, input tx_ready,
                  input rx_data, rx_valid, rx_last, output rx_ready);
  modport remote (input tx_data, tx_valid, tx_last, output tx_ready,
                  output rx_data, rx_valid, rx_last, input rx_ready);
endinterface
`default_nettype wire

// file: design/nvpc_remote.sv
// Purpose: remote node end; sends messages and answers polls
// Assumes: one shared variable with a fixed selector, size and direction
// Notes: sends on rx_* of the link, receives on tx_*
`timescale 1ns/100ps
`default_nettype none
module nvpc_remote
  import nvpc_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // own variable
  input wire logic [NVPC_SEL_W-1:0] i_var_sel,
  input wire logic [5:0] i_var_len,
  input wire logic i_var_is_out,
  input wire logic [NVPC_VAL_W-1:0] i_var_val,
  input wire logic i_online,
  // send request: a poll
  input wire logic i_poll_go,
  input wire logic [NVPC_SEL_W-1:0] i_poll_sel,
  output logic o_busy,
  // link
  nvpc_link_if.remote lk
);
  typedef enum {NVPC_R_IDLE, NVPC_R_HDR, NVPC_R_LO, NVPC_R_DAT,
                NVPC_R_SKIP} nvpc_rst_t;
  nvpc_rst_t st_r, st_nxt;
  logic [7:0] code_r, code_nxt;
  logic [7:0] lo_r, lo_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic busy_r, busy_nxt;
  logic [7:0] rxd_r, rxd_nxt;
  logic rxv_r, rxv_nxt;
  logic rxl_r, rxl_nxt;
  logic hit;
  logic [1:0] bidx;

  assign lk.tx_ready = 1'b1;
  assign lk.rx_data = rxd_r;
  assign lk.rx_valid = rxv_r;
  assign lk.rx_last = rxl_r;
  assign o_busy = busy_r;
  assign bidx = 2'(cnt_r - 6'h01);

  // next state: poll out, or poll in and answer
  always_comb begin
    st_nxt = st_r;
    code_nxt = code_r;
    lo_nxt = lo_r;
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    rxd_nxt = rxd_r;
    rxv_nxt = rxv_r;
    rxl_nxt = rxl_r;
    hit = {code_r[NVPC_HI_W-1:0], lo_r} == i_var_sel;
    case (st_r)
      NVPC_R_IDLE: begin
        if (i_poll_go) begin
          // both top bits set, selector high six bits
          rxd_nxt = {NVPC_POLL_TOP, i_poll_sel[NVPC_SEL_W-1:NVPC_LO_W]};
          rxv_nxt = 1'b1;
          rxl_nxt = 1'b0;
          lo_nxt = i_poll_sel[NVPC_LO_W-1:0];
          busy_nxt = 1'b1;
          st_nxt = NVPC_R_LO;
          cnt_nxt = 6'h00;
        end else if (lk.tx_valid) begin
          code_nxt = lk.tx_data;
          st_nxt = lk.tx_last ? NVPC_R_IDLE : NVPC_R_SKIP;
          if (lk.tx_data[7:6] == NVPC_POLL_TOP && !lk.tx_last) begin
            st_nxt = NVPC_R_HDR;
          end
        end
      end
      NVPC_R_HDR: begin
        if (lk.tx_valid) begin
          lo_nxt = lk.tx_data;
          busy_nxt = 1'b1;
          // answer code is the request code with bit six cleared
          rxd_nxt = code_r & 8'hBF;
          rxv_nxt = 1'b1;
          rxl_nxt = 1'b0;
          cnt_nxt = 6'h01;
          st_nxt = lk.tx_last ? NVPC_R_LO : NVPC_R_SKIP;
        end
      end
      NVPC_R_LO: begin
        if (lk.rx_ready) begin
          rxd_nxt = lo_r;
          // answer with data only when matching output and online
          rxl_nxt = (cnt_r == 6'h00) || !(hit && i_online && i_var_is_out);
          st_nxt = NVPC_R_DAT;
          cnt_nxt = (cnt_r != 6'h00 && hit && i_online && i_var_is_out)
                    ? i_var_len : 6'h00;
        end
      end
      NVPC_R_DAT: begin
        if (lk.rx_ready) begin
          if (cnt_r == 6'h00) begin
            rxv_nxt = 1'b0;
            rxl_nxt = 1'b0;
            busy_nxt = 1'b0;
            st_nxt = NVPC_R_IDLE;
          end else begin
            // value goes most significant byte first
            rxd_nxt = i_var_val[8*bidx +: 8];
            rxl_nxt = cnt_r == 6'h01;
            cnt_nxt = cnt_r - 6'h01;
          end
        end
      end
      NVPC_R_SKIP: begin
        if (lk.tx_valid && lk.tx_last) begin
          st_nxt = (busy_r && cnt_r == 6'h01) ? NVPC_R_LO : NVPC_R_IDLE;
        end
      end
      default: st_nxt = NVPC_R_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      st_r <= NVPC_R_IDLE;
      code_r <= NVPC_ZERO_B;
      lo_r <= NVPC_ZERO_B;
      cnt_r <= 6'h00;
      busy_r <= 1'b0;
      rxd_r <= NVPC_ZERO_B;
      rxv_r <= 1'b0;
      rxl_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      code_r <= code_nxt;
      lo_r <= lo_nxt;
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      rxd_r <= rxd_nxt;
      rxv_r <= rxv_nxt;
      rxl_r <= rxl_nxt;
    end
  end
endmodule
`default_nettype wire

// file: test/nvpc_link_asserts.sv
// Purpose: wire-level checks on the link between the two codec ends
// Assumes: one clock, a byte moves when valid and ready are both high
// Notes: a small tracker follows the framing of each direction
`timescale 1ns/100ps
`default_nettype none
module nvpc_frame_trk (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // watched stream
  input wire logic i_fire,
  input wire logic i_last,
  input wire logic [7:0] i_data,
  // framing state
  output logic o_first,
  output logic [7:0] o_cnt,
  output logic [7:0] o_code,
  output logic [7:0] o_low
);
  logic first_nxt;
  logic [7:0] cnt_nxt, code_nxt, low_nxt;
  // next framing state after each accepted byte
  always_comb begin
    first_nxt = i_fire ? i_last : o_first;
    code_nxt = (i_fire && o_first) ? i_data : o_code;
    low_nxt = (i_fire && o_cnt == 8'h01) ? i_data : o_low;
    cnt_nxt = !i_fire ? o_cnt : (i_last ? 8'h00 : o_cnt + 8'h01);
  end
  // register framing state
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_first <= 1'h1;
      o_cnt <= 8'h00;
      o_code <= 8'h00;
      o_low <= 8'h00;
    end else begin
      o_first <= first_nxt;
      o_cnt <= cnt_nxt;
      o_code <= code_nxt;
      o_low <= low_nxt;
    end
  end
endmodule

module nvpc_link_asserts (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // link signals
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic tx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_last,
  input wire logic rx_ready
);
  logic tx_f, rx_f, t_first, r_first;
  logic [7:0] t_cnt, t_code, t_low, r_cnt, r_code, r_low;
  assign tx_f = tx_valid && tx_ready;
  assign rx_f = rx_valid && rx_ready;
  // framing trackers for both directions
  nvpc_frame_trk tx_trk_i (.i_ref_clk, .i_rstn, .i_fire(tx_f),
    .i_last(tx_last), .i_data(tx_data), .o_first(t_first),
    .o_cnt(t_cnt), .o_code(t_code), .o_low(t_low));
  nvpc_frame_trk rx_trk_i (.i_ref_clk, .i_rstn, .i_fire(rx_f),
    .i_last(rx_last), .i_data(rx_data), .o_first(r_first),
    .o_cnt(r_cnt), .o_code(r_code), .o_low(r_low));
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);
  // poll request codes on each direction
  sequence s_tx_poll;
    tx_f && t_first && tx_data[7:6] == 2'h3;
  endsequence
  sequence s_rx_poll;
    rx_f && r_first && rx_data[7:6] == 2'h3;
  endsequence
  a_poll_req_len: assert property (s_tx_poll |=> tx_f && tx_last)
    else $error("poll request not exactly two bytes");
  a_nv_has_value: assert property (tx_f && t_first &&
    tx_data[7:6] == 2'h2 && r_code[7:6] != 2'h3
    |=> tx_f && !tx_last ##1 tx_f)
    else $error("update without value byte");
  a_frn_nibble: assert property (tx_f && t_first &&
    tx_data[7:6] == 2'h1 |-> tx_data[5:4] == 2'h0)
    else $error("foreign code upper nibble wrong");
  a_tx_nv_max: assert property (tx_f && t_code[7] && !t_first
    |-> t_cnt <= 8'h20)
    else $error("sent value too long");
  a_tx_msg_max: assert property (tx_f |-> t_cnt <= 8'hF9)
    else $error("sent message too long");
  a_rx_nv_max: assert property (rx_f && !r_first |-> r_cnt <= 8'h20)
    else $error("received value too long");
  a_rx_nv_top: assert property (rx_f && r_first |-> rx_data[7])
    else $error("remote code byte top bit clear");
  a_remote_resp: assert property (s_tx_poll ##1 (tx_f && tx_last)
    |-> ##[1:8] (rx_f && r_first && rx_data == (t_code & 8'hBF))
    ##1 (rx_f && rx_data == t_low))
    else $error("remote answer wrong");
  a_device_resp: assert property (s_rx_poll ##1 (rx_f && rx_last)
    |-> ##[1:8] (tx_f && t_first && tx_data == (r_code & 8'hBF))
    ##1 (tx_f && tx_data == r_low))
    else $error("device answer wrong");
endmodule
`default_nettype wire

// file: test/nvpc_codec_tb.sv
// Purpose: self-checking bench with device and remote ends joined
// Assumes: remote answers polls, both ready lines held high
// Notes: byte monitors collect each direction of the link
`timescale 1ns/100ps
`default_nettype none
module nvpc_codec_tb
  import nvpc_pkg::*;
;
  logic i_ref_clk = 1'h0, i_rstn = 1'h0, i_send = 1'h0, i_tab_we = 1'h0;
  logic i_tab_out = 1'h0, i_timeout = 1'h0, i_var_is_out = 1'h0;
  logic i_online = 1'h0, i_poll_go = 1'h0, o_busy, r_busy, o_unknown;
  logic o_upd_evt, o_upd_ok, o_upd_fail;
  nvpc_kind_t i_kind = NVPC_K_UPD;
  logic [13:0] i_sel = '0, i_tab_sel = '0, i_var_sel = '0;
  logic [13:0] i_poll_sel = '0, o_rx_sel;
  logic [5:0] i_code = '0, i_tab_len = '0, i_var_len = '0;
  logic [7:0] i_len = '0;
  logic [3:0] i_expect = '0;
  logic [1:0] i_tab_idx = '0;
  logic [31:0] i_val = '0, i_tab_val = '0, i_var_val = '0, o_fetch_val;
  logic signed [15:0] i_scale_a = '0;
  logic signed [3:0] i_scale_b = '0;
  logic signed [31:0] i_scale_c = '0, i_min = '0, i_max = '0;
  logic signed [31:0] i_invalid = '0;
  logic signed [63:0] o_scaled;
  logic [7:0] txq[$], rxq[$];
  int n_fail = 0, comparisons = 0, n_evt = 0, n_ok = 0, n_ufail = 0;
  int cyc = 0;
  always #10 i_ref_clk = ~i_ref_clk;
  // -----------------------------------------------------------------
  // ends, link and checker
  // -----------------------------------------------------------------
  nvpc_link_if lk (.i_ref_clk);
  nvpc_device nvpc_device_i (.i_ref_clk, .i_rstn, .i_send, .i_kind,
    .i_sel, .i_code, .i_len, .i_val, .i_expect, .o_busy, .i_tab_we,
    .i_tab_idx, .i_tab_sel, .i_tab_len, .i_tab_out, .i_tab_val,
    .o_fetch_val, .i_scale_a, .i_scale_b, .i_scale_c, .i_min, .i_max,
    .i_invalid, .o_scaled, .o_unknown, .i_timeout, .o_upd_evt,
    .o_upd_ok, .o_upd_fail, .o_rx_sel, .lk(lk));
  nvpc_remote nvpc_remote_i (.i_ref_clk, .i_rstn, .i_var_sel,
    .i_var_len, .i_var_is_out, .i_var_val, .i_online, .i_poll_go,
    .i_poll_sel, .o_busy(r_busy), .lk(lk));
  nvpc_link_asserts nvpc_link_asserts_i (.i_ref_clk, .i_rstn,
    .tx_data(lk.tx_data), .tx_valid(lk.tx_valid), .tx_last(lk.tx_last),
    .tx_ready(lk.tx_ready), .rx_data(lk.rx_data), .rx_valid(lk.rx_valid),
    .rx_last(lk.rx_last), .rx_ready(lk.rx_ready));
  // byte monitors, event counters and hang limit
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (lk.tx_valid === 1'h1 && lk.tx_ready === 1'h1) txq.push_back(lk.tx_data);
    if (lk.rx_valid === 1'h1 && lk.rx_ready === 1'h1) rxq.push_back(lk.rx_data);
    if (o_upd_evt === 1'h1) n_evt <= n_evt + 1;
    if (o_upd_ok === 1'h1) n_ok <= n_ok + 1;
    if (o_upd_fail === 1'h1) n_ufail <= n_ufail + 1;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  // -----------------------------------------------------------------
  // compare, access and closing tasks
  // -----------------------------------------------------------------
  task automatic chk_w(input string nm, input logic [63:0] e, g);
    comparisons++;
    if (e !== g) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_q(input string nm, input logic [7:0] e[$], g[$]);
    chk_w({nm, " count"}, 64'(e.size()), 64'(g.size()));
    foreach (e[k])
      if (k < g.size())
        chk_w(nm, {56'h0, e[k]}, {56'h0, g[k]});
  endtask
  // wait for four idle cycles on both ends
  task automatic quiet();
    int k, idle;
    k = 0;
    idle = 0;
    while (idle < 4 && k < 600) begin
      @(posedge i_ref_clk);
      k++;
      idle = (o_busy === 1'h0 && r_busy === 1'h0 &&
        lk.rx_valid === 1'h0) ? idle + 1 : 0;
    end
    if (k == 600) n_fail++;
  endtask
  task automatic send_msg(input nvpc_kind_t k, input logic [13:0] s,
    input logic [5:0] c, input logic [7:0] n, input logic [3:0] x);
    txq.delete();
    rxq.delete();
    i_kind <= k;
    i_sel <= s;
    i_code <= c;
    i_len <= n;
    i_val <= 32'h00AB_CDEF;
    i_expect <= x;
    i_send <= 1'h1;
    @(posedge i_ref_clk);
    i_send <= 1'h0;
    quiet();
  endtask
  task automatic tab(input logic [1:0] ix, input logic [13:0] s,
    input logic [5:0] n, input logic o, input logic [31:0] v);
    i_tab_idx <= ix;
    i_tab_sel <= s;
    i_tab_len <= n;
    i_tab_out <= o;
    i_tab_val <= v;
    i_tab_we <= 1'h1;
    @(posedge i_ref_clk);
    i_tab_we <= 1'h0;
    @(posedge i_ref_clk);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // -----------------------------------------------------------------
  // test sequence
  // -----------------------------------------------------------------
  initial begin
    nvpc_kind_t kk[5] = '{NVPC_K_UPD, NVPC_K_UPD, NVPC_K_APP,
      NVPC_K_APP, NVPC_K_FRN};
    logic [7:0] ln[5] = '{8'h00, 8'h28, 8'h00, 8'hFA, 8'h07};
    int nb[5] = '{3, 33, 1, 250, 8};
    logic [7:0] cb[5] = '{8'h80, 8'h80, 8'h15, 8'h15, 8'h4B};
    repeat (12) @(posedge i_ref_clk);
    i_rstn <= 1'h1;
    @(posedge i_ref_clk);
    tab(2'h1, 14'h1234, 6'h04, 1'h0, 32'h0000_0000);
    tab(2'h2, 14'h0F0F, 6'h01, 1'h1, 32'h0000_005A);
    tab(2'h0, 14'h1234, 6'h02, 1'h0, 32'h0000_0000);
    // update with value msb first
    send_msg(NVPC_K_UPD, 14'h2A5C, 6'h00, 8'h03, 4'h0);
    chk_q("update", '{8'hAA, 8'h5C, 8'hAB, 8'hCD, 8'hEF}, txq);
    // length limits and code bytes of update, app and foreign sends
    for (int i = 0; i < 5; i++) begin
      send_msg(kk[i], 14'h0001, (i < 4) ? 6'h15 : 6'h3B, ln[i], 4'h0);
      chk_w("length", 64'(nb[i]), 64'(txq.size()));
      chk_w("code", {56'h0, cb[i]}, {56'h0, txq[0]});
    end
    // poll of a matching online output
    i_var_sel <= 14'h1234;
    i_var_len <= 6'h02;
    i_var_is_out <= 1'h1;
    i_var_val <= 32'h0000_BEEF;
    i_online <= 1'h1;
    send_msg(NVPC_K_POLL, 14'h1234, 6'h00, 8'h00, 4'h1);
    chk_q("poll", '{8'hD2, 8'h34}, txq);
    chk_q("answer", '{8'h92, 8'h34, 8'hBE, 8'hEF}, rxq);
    chk_w("updated", 64'h0000_BEEF, {32'h0, o_fetch_val});
    i_tab_idx <= 2'h1;
    @(posedge i_ref_clk);
    chk_w("size mismatch", 64'h0, {32'h0, o_fetch_val});
    chk_w("events", 64'h1, 64'(n_evt));
    chk_w("success", 64'h1, 64'(n_ok));
    chk_w("selector", 64'h1234, {50'h0, o_rx_sel});
    // offline node, then an input variable: empty answers
    for (int i = 0; i < 2; i++) begin
      i_online <= 1'(i);
      i_var_is_out <= 1'(1 - i);
      send_msg(NVPC_K_POLL, 14'h1234, 6'h00, 8'h00, 4'h1);
      chk_q("empty", '{8'h92, 8'h34}, rxq);
      chk_w("events", 64'(2 + i), 64'(n_evt));
    end
    // group poll with one member missing
    send_msg(NVPC_K_POLL, 14'h1234, 6'h00, 8'h00, 4'h2);
    for (int i = 0; i < 4; i++) begin
      chk_w("failure", 64'h0, 64'(n_ufail));
      i_timeout <= 1'h1;
      @(posedge i_ref_clk);
      i_timeout <= 1'h0;
      repeat (3) @(posedge i_ref_clk);
    end
    chk_w("failure", 64'h1, 64'(n_ufail));
    chk_w("success", 64'h3, 64'(n_ok));
    // remote polls a local output
    txq.delete();
    rxq.delete();
    i_poll_sel <= 14'h0F0F;
    i_poll_go <= 1'h1;
    @(posedge i_ref_clk);
    i_poll_go <= 1'h0;
    quiet();
    chk_q("remote poll", '{8'hCF, 8'h0F}, rxq);
    chk_q("local answer", '{8'h8F, 8'h0F, 8'h5A}, txq);
    // scaling, clamping and the invalid marker
    i_tab_idx <= 2'h0;
    i_scale_a <= 16'sh0005;
    i_scale_c <= 32'sh0000_0003;
    i_max <= 32'sh7FFF_FFFF;
    i_invalid <= -32'sh0000_0001;
    repeat (3) @(posedge i_ref_clk);
    chk_w("scaled", 64'h0000_0000_0003_BABA, o_scaled);
    chk_w("unknown", 64'h0, {63'h0, o_unknown});
    i_scale_a <= 16'sh0001;
    i_scale_c <= 32'sh0000_0000;
    i_max <= 32'sh0000_0064;
    i_invalid <= 32'sh0000_BEEF;
    repeat (3) @(posedge i_ref_clk);
    chk_w("clamped", 64'h0000_0000_0000_0064, o_scaled);
    chk_w("unknown", 64'h1, {63'h0, o_unknown});
    results();
  end
endmodule
`default_nettype wire
